/* File: rtl/bdp_map.vh */
// command codes, field positions, reset values and timing counts of the backlight fade and pwm block
`ifndef BDP_MAP_VH
`define BDP_MAP_VH
`define BDP_CMD_FADE_MS     8'hcd
`define BDP_CMD_STEP_UI     8'hce
`define BDP_CMD_PWM_DIV     8'hcf
`define BDP_STILL_LSB       0
`define BDP_MOVING_LSB      4
`define BDP_UI_LSB          0
`define BDP_MINSTEP_LSB     4
`define BDP_RST_FADE_MS     8'h00
`define BDP_RST_STEP_UI     8'h00
`define BDP_RST_PWM_DIV     8'h00
`define BDP_PWM_STEPS       8'hfe
`define BDP_FADE_MS_MASK    8'h77
`define BDP_STEP_UI_MASK    8'hf7
`define BDP_MODE_MOVING     2'h0
`define BDP_MODE_STILL      2'h1
`define BDP_MODE_UI         2'h2
`endif

/* File: rtl/bdp_sync3.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bdp_sync3 (
    input  wire sys_clk,
    input  wire reset_n,
    input  wire asyncIn,
    output reg  syncOut
);
    reg s1Q;
    reg s2Q;
    reg s3Q;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1Q     <= 1'b0;
            s2Q     <= 1'b0;
            s3Q     <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            s1Q <= asyncIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                syncOut <= s3Q;
            end
        end
    end
endmodule // bdp_sync3

/* File: rtl/bdp_backlight_pwm.v */
// backlight fade control and pwm generator behind the parallel command bus
`timescale 1ns/1ps
`include "bdp_map.vh"
// Behaviour
// R1 - command cd with select low, then one parameter with select high, sets both fade times.
// R2 - bits 2:0 of the cd parameter are the still fade time, bit 3 is zero.
// R3 - bits 6:4 of the cd parameter are the moving fade time, bit 7 is zero.
// R4 - fade codes 0 and 1 give 1 frame, then 2, 4, 8, 16, 32 and 64 frames.
// R5 - command ce takes bits 7:4 as the minimum step and bits 2:0 as the ui fade time.
// R6 - in ui mode each brightness change is spread over the ui fade frames.
// R7 - when the minimum step exceeds the target to current difference the brightness stays.
// R8 - command cf stores its whole parameter byte as the pwm divider.
// R9 - pwm frequency is the clock divided by divider plus one and then by 255.
// R10 - a pwm period is 255 prescaled counts, high while below the duty latched at period end.
// R11 - brightness steps toward the target once per frame and ends within the fade frames; the code latches the target first and ends one frame later.
module bdp_backlight_pwm (
    input  wire       sys_clk,
    input  wire       reset_n,
    input  wire       cmdParamSelect,
    input  wire       writeStrobe,
    input  wire [7:0] busData,
    input  wire [1:0] imageMode,
    input  wire [7:0] targetBright,
    input  wire       frameStart,
    output wire [7:0] currentBright,
    output wire       pwmOut
);
    // ============================================================
    // pin synchronisers
    wire       dcSync;
    wire       wrLow;
    wire       wrLowSync;
    wire [7:0] dataSync;
    bdp_sync3 uSyncDc (.sys_clk(sys_clk), .reset_n(reset_n), .asyncIn(cmdParamSelect),
                       .syncOut(dcSync));
    // the strobe idles high; syncing its inverse makes the reset level match the idle level
    assign wrLow = ~writeStrobe;
    bdp_sync3 uSyncWr (.sys_clk(sys_clk), .reset_n(reset_n), .asyncIn(wrLow),
                       .syncOut(wrLowSync));
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : gData
            bdp_sync3 uSyncD (.sys_clk(sys_clk), .reset_n(reset_n), .asyncIn(busData[gi]),
                              .syncOut(dataSync[gi]));
        end
    endgenerate
    // ============================================================
    // command decode
    // a parameter with no command before it, or a second one, is dropped
    localparam [1:0] ST_CMD   = 2'h0;
    localparam [1:0] ST_PARAM = 2'h1;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg        wrLowPrev_q;
    reg  [7:0] lastCmd_q;
    reg  [7:0] lastCmd_d;
    reg  [7:0] fadeMs_q;
    reg  [7:0] fadeMs_d;
    reg  [7:0] stepUi_q;
    reg  [7:0] stepUi_d;
    reg  [7:0] pwmDiv_q;
    reg  [7:0] pwmDiv_d;
    // the strobe pin rises when its synced low phase ends
    wire       wrRise = wrLowPrev_q & ~wrLowSync;
    always @* begin
        state_d   = state_q;
        lastCmd_d = lastCmd_q;
        fadeMs_d  = fadeMs_q;
        stepUi_d  = stepUi_q;
        pwmDiv_d  = pwmDiv_q;
        if (wrRise && !dcSync) begin
            lastCmd_d = dataSync; // R1
            state_d   = ST_PARAM;
        end else if (wrRise) begin
            case (state_q)
                ST_PARAM: begin
                    state_d = ST_CMD;
                    case (lastCmd_q)
                        `BDP_CMD_FADE_MS: fadeMs_d = dataSync & `BDP_FADE_MS_MASK; // R1 R2 R3
                        `BDP_CMD_STEP_UI: stepUi_d = dataSync & `BDP_STEP_UI_MASK; // R5
                        `BDP_CMD_PWM_DIV: pwmDiv_d = dataSync; // R8
                        default:          state_d  = ST_CMD;
                    endcase
                end
                default: state_d = ST_CMD;
            endcase
        end
    end
    // the last command byte stays until the next command arrives
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= ST_CMD;
            wrLowPrev_q <= 1'b0;
            lastCmd_q   <= 8'h00;
            fadeMs_q    <= `BDP_RST_FADE_MS;
            stepUi_q    <= `BDP_RST_STEP_UI;
            pwmDiv_q    <= `BDP_RST_PWM_DIV;
        end else begin
            state_q     <= state_d;
            wrLowPrev_q <= wrLowSync;
            lastCmd_q   <= lastCmd_d;
            fadeMs_q    <= fadeMs_d;
            stepUi_q    <= stepUi_d;
            pwmDiv_q    <= pwmDiv_d;
        end
    end
    // ============================================================
    // register fields
    wire [2:0] stillFadeTime  = fadeMs_q[`BDP_STILL_LSB+2:`BDP_STILL_LSB]; // R2
    wire [2:0] movingFadeTime = fadeMs_q[`BDP_MOVING_LSB+2:`BDP_MOVING_LSB]; // R3
    wire [2:0] uiFadeTime     = stepUi_q[`BDP_UI_LSB+2:`BDP_UI_LSB]; // R5
    wire [3:0] minBrightStep  = stepUi_q[`BDP_MINSTEP_LSB+3:`BDP_MINSTEP_LSB];
    // ============================================================
    // fade stepping
    reg  [2:0] fadeCode;
    reg  [6:0] fadeFrames;
    always @* begin
        case (imageMode)
            `BDP_MODE_STILL: fadeCode = stillFadeTime;
            `BDP_MODE_UI:    fadeCode = uiFadeTime; // R6
            // mode 3 is not defined and falls back to moving
            default:         fadeCode = movingFadeTime;
        endcase
        case (fadeCode) // R4
            3'h2:    fadeFrames = 7'h02;
            3'h3:    fadeFrames = 7'h04;
            3'h4:    fadeFrames = 7'h08;
            3'h5:    fadeFrames = 7'h10;
            3'h6:    fadeFrames = 7'h20;
            3'h7:    fadeFrames = 7'h40;
            default: fadeFrames = 7'h01;
        endcase
    end
    // fadeTarget_q is the target that the running fade heads for
    reg  [7:0] currentBright_q;
    reg  [7:0] currentBright_d;
    reg  [7:0] fadeTarget_q;
    reg  [7:0] fadeTarget_d;
    reg  [6:0] framesLeft_q;
    reg  [6:0] framesLeft_d;
    wire [7:0] diffNow  = (targetBright > currentBright_q) ? (targetBright - currentBright_q)
                                                           : (currentBright_q - targetBright);
    wire       blocked  = ({4'h0, minBrightStep} > diffNow); // R7
    wire [7:0] span     = (fadeTarget_q > currentBright_q) ? (fadeTarget_q - currentBright_q)
                                                           : (currentBright_q - fadeTarget_q);
    // nine bits, since span plus frames left overflows eight before the division
    wire [8:0] stepSum  = {1'b0, span} + {2'b00, framesLeft_q} - 9'h001;
    wire [8:0] stepQuot = stepSum / {2'b00, framesLeft_q};
    wire [7:0] stepAmt  = (framesLeft_q <= 7'h01) ? span : stepQuot[7:0];
    always @* begin
        currentBright_d = currentBright_q;
        fadeTarget_d    = fadeTarget_q;
        framesLeft_d    = framesLeft_q;
        if (frameStart) begin
            if (targetBright != fadeTarget_q) begin
                // a blocked target freezes the brightness until the target moves again
                if (!blocked) begin // R7
                    fadeTarget_d = targetBright;
                    framesLeft_d = fadeFrames;
                end
            end else if (framesLeft_q != 7'h00) begin
                framesLeft_d = framesLeft_q - 7'h01; // R11
                if (fadeTarget_q > currentBright_q) begin
                    currentBright_d = currentBright_q + stepAmt; // R11
                end else begin
                    currentBright_d = currentBright_q - stepAmt; // R11
                end
            end
        end
    end
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            currentBright_q <= 8'h00;
            fadeTarget_q    <= 8'h00;
            framesLeft_q    <= 7'h00;
        end else begin
            currentBright_q <= currentBright_d;
            fadeTarget_q    <= fadeTarget_d;
            framesLeft_q    <= framesLeft_d;
        end
    end
    // ============================================================
    // pwm generator
    reg  [7:0] preCnt_q;
    reg  [7:0] preCnt_d;
    reg  [7:0] phase_q;
    reg  [7:0] phase_d;
    reg  [7:0] duty_q;
    reg  [7:0] duty_d;
    reg        pwmOut_q;
    reg        pwmOut_d;
    // prescaler runs 0 to divider, so each phase lasts divider plus one clocks
    wire       tick = (preCnt_q == pwmDiv_q); // R9
    always @* begin
        preCnt_d = tick ? 8'h00 : preCnt_q + 8'h01; // R9
        phase_d  = phase_q;
        duty_d   = duty_q;
        if (tick) begin
            if (phase_q == `BDP_PWM_STEPS) begin
                // duty only moves at the period boundary so no pulse is cut short
                phase_d = 8'h00; // R10
                duty_d  = currentBright_q; // R10
            end else begin
                phase_d = phase_q + 8'h01;
            end
        end
        pwmOut_d = (phase_q < duty_q); // R10
    end
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            preCnt_q <= 8'h00;
            phase_q  <= 8'h00;
            duty_q   <= 8'h00;
            pwmOut_q <= 1'b0;
        end else begin
            preCnt_q <= preCnt_d;
            phase_q  <= phase_d;
            duty_q   <= duty_d;
            pwmOut_q <= pwmOut_d;
        end
    end
    // ============================================================
    // outputs
    assign currentBright = currentBright_q;
    assign pwmOut        = pwmOut_q;
endmodule // bdp_backlight_pwm

/* File: testbench/bdp_backlight_pwm_chk.sv */
// port assertions for the backlight fade and pwm block
`timescale 1ns/1ps
module bdp_backlight_pwm_chk (
    input wire       sys_clk,
    input wire       reset_n,
    input wire [7:0] targetBright,
    input wire       frameStart,
    input wire [7:0] currentBright,
    input wire       pwmOut
);
    // ====================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_reset_clear: assert property (disable iff (1'b0)
        !reset_n |-> currentBright == 8'h00 && !pwmOut) else $error("reset not clearing");
    a_pwm_quiet_start: assert property ($rose(reset_n) |-> !pwmOut [*8])
        else $error("pwm high after reset");
    a_bright_quiet_start: assert property ($rose(reset_n) |-> (currentBright == 8'h00) [*2])
        else $error("brightness moved at reset release");
    a_hold_between: assert property (!frameStart && !$past(frameStart)
        |=> $stable(currentBright)) else $error("brightness moved between frames");
    a_rise_bounded: assert property (frameStart && targetBright >= currentBright
        |=> currentBright >= $past(currentBright) && currentBright <= $past(targetBright))
        else $error("upward step wrong");
    a_fall_bounded: assert property (frameStart && targetBright <= currentBright
        |=> currentBright <= $past(currentBright) && currentBright >= $past(targetBright))
        else $error("downward step wrong");
    a_hold_at_target: assert property (frameStart && targetBright == currentBright
        |=> currentBright == $past(currentBright)) else $error("moved at target");
    a_pwm_rise_duty: assert property ($rose(pwmOut) |-> (($past(currentBright) |
        $past(currentBright, 2) | $past(currentBright, 3)) != 8'h00))
        else $error("pwm with zero duty");
endmodule // bdp_backlight_pwm_chk
bind bdp_backlight_pwm bdp_backlight_pwm_chk CHK (.sys_clk(sys_clk), .reset_n(reset_n),
    .targetBright(targetBright), .frameStart(frameStart), .currentBright(currentBright),
    .pwmOut(pwmOut));

/* File: testbench/bdp_host_model.sv */
// host model writing command and parameter bytes on the parallel bus
`timescale 1ns/1ps
module bdp_host_model (
    input  wire        sys_clk,
    output logic       cmdParamSelect,
    output logic       writeStrobe,
    output logic [7:0] busData
);
    // ====================
    // bus cycles
    initial begin
        cmdParamSelect = 1'b0;
        writeStrobe = 1'b1;
        busData = 8'h00;
    end
    task automatic put(input logic sel, input logic [7:0] val);
        @(negedge sys_clk);
        cmdParamSelect = sel;
        busData = val;
        writeStrobe = 1'b0;
        repeat (6) @(negedge sys_clk);
        writeStrobe = 1'b1;
        repeat (6) @(negedge sys_clk);
        busData = ~val;
    endtask
    task automatic send(input logic [7:0] cmd, input logic [7:0] par);
        put(1'b0, cmd);
        put(1'b1, par);
    endtask
endmodule // bdp_host_model

/* File: testbench/bdp_backlight_pwm_tb.sv */
// self-checking bench for the backlight fade and pwm block
`timescale 1ns/1ps
module bdp_backlight_pwm_tb;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b1;
    logic [1:0] imageMode = 2'h0;
    logic [7:0] targetBright = 8'h00;
    logic       frameStart = 1'b0;
    wire        cmdParamSelect, writeStrobe, pwmOut;
    wire  [7:0] busData, currentBright;
    int         mismatches = 0;
    int         checked = 0;
    // ====================
    // clock, host and block
    initial forever #5 sys_clk = ~sys_clk;
    bdp_host_model HOST (.sys_clk(sys_clk), .cmdParamSelect(cmdParamSelect),
        .writeStrobe(writeStrobe), .busData(busData));
    bdp_backlight_pwm DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cmdParamSelect(cmdParamSelect),
        .writeStrobe(writeStrobe), .busData(busData), .imageMode(imageMode),
        .targetBright(targetBright), .frameStart(frameStart), .currentBright(currentBright),
        .pwmOut(pwmOut));
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input bit same);
        checked++;
        if ($isunknown(got) || ((got === exp) !== same)) begin
            mismatches++;
            $display("unexpected at %0t: value %0d", $time, got);
        end
    endtask
    task automatic frames(input int n);
        repeat (n) begin
            @(negedge sys_clk) frameStart = 1'b1;
            @(negedge sys_clk) frameStart = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask
    task automatic fade(input logic [1:0] mode, input logic [7:0] tgt, input int n);
        imageMode = mode;
        targetBright = tgt;
        frames(n);
        chk(currentBright, tgt, 1'b0);
        frames(1);
        chk(currentBright, tgt, 1'b1);
    endtask
    task automatic wait_pwm(input logic lvl, output int n);
        n = 0;
        while (pwmOut !== lvl) begin
            @(negedge sys_clk) n++;
            if (n > 2000) begin
                mismatches++;
                end_of_test();
            end
        end
    endtask
    // ====================
    // scenarios
    task automatic t_fade();
        HOST.send(8'hcd, 8'hd9);
        HOST.send(8'hce, 8'h0a);
        fade(2'h0, 8'd100, 16);
        fade(2'h1, 8'd40, 1);
        fade(2'h2, 8'd60, 2);
        $display("fade test done");
    endtask
    task automatic t_min_step();
        HOST.send(8'hce, 8'hfa);
        targetBright = 8'd74;
        frames(4);
        chk(currentBright, 16'd60, 1'b1);
        fade(2'h2, 8'd75, 2);
        $display("min step test done");
    endtask
    task automatic t_pwm();
        int hi;
        int lo;
        for (int d = 0; d < 3; d += 2) begin
            HOST.send(8'hcf, 8'(d));
            if (d == 2) begin
                HOST.put(1'b1, 8'h00);
                HOST.send(8'hcc, 8'h00);
            end
            repeat (2) begin
                wait_pwm(1'b0, hi);
                wait_pwm(1'b1, hi);
            end
            wait_pwm(1'b0, hi);
            wait_pwm(1'b1, lo);
            chk(16'(hi), 16'(75 * (d + 1)), 1'b1);
            chk(16'(hi + lo), 16'(255 * (d + 1)), 1'b1);
        end
        $display("pwm test done");
    endtask
    task automatic t_codes();
        for (int c = 0; c < 8; c++) begin
            HOST.send(8'hce, 8'(c));
            fade(2'h2, (c % 2) ? 8'd0 : 8'd200, (c < 2) ? 1 : (1 << (c - 1)));
        end
        fade(2'h3, 8'd100, 16);
        $display("fade code test done");
    endtask
    initial begin
        #1 reset_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        t_fade();
        t_min_step();
        t_pwm();
        t_codes();
        end_of_test();
    end
endmodule // bdp_backlight_pwm_tb
